/* core/crb_pkg.sv */
package crb_pkg;

	// ----------------------------------------
	// Memory geometry
	// ----------------------------------------
	localparam int CRB_WORDS = 40;
	localparam int CRB_BLOCKS = 5;
	localparam int CRB_BLK_WORDS = 8;
	localparam int CRB_BLK_W = 3;
	localparam int CRB_IDX_W = 3;
	localparam int CRB_ADDR_W = 6;
	localparam int CRB_DATA_W = 16;
	localparam logic [2:0] CRB_IDX_FIRST = 3'h7;
	localparam logic [2:0] CRB_IDX_LAST = 3'h0;
	localparam logic [2:0] CRB_BLK_MAX = 3'h4;

	// ----------------------------------------
	// Block codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		CRB_IMPEDANCE_MATCHING_SET = 3'h0,
		CRB_BALANCE_FILTER_SET = 3'h1,
		CRB_IMPEDANCE_SCALING_SET = 3'h2,
		CRB_TRANSMIT_SET = 3'h3,
		CRB_RECEIVE_SET = 3'h4
	} crb_blk_t;

	// ----------------------------------------
	// Functional set selects, one hot
	// ----------------------------------------
	typedef struct packed {
		logic impedance_matching_set;
		logic balance_filter_set;
		logic impedance_scaling_set;
		logic transmit_gain_set;
		logic transmit_freq_response_set;
		logic receive_gain_set;
		logic receive_freq_response_set;
	} crb_sel_t;

	typedef struct packed {
		logic write;
		logic [2:0] block;
	} crb_cmd_t;

	localparam logic [2:0] CRB_GAIN_HALF_MIN = 3'h4;

endpackage : crb_pkg

/* core/crb_decode.sv */
`timescale 1ns/100ps
module crb_decode
	import crb_pkg::*;
(
	input wire logic [2:0] block,
	input wire logic [2:0] index,
	output crb_sel_t sel,
	output logic valid
);

	always_comb begin
		sel = '0;
		valid = 1'b1;
		case (block)
			CRB_IMPEDANCE_MATCHING_SET: sel.impedance_matching_set = 1'b1;
			CRB_BALANCE_FILTER_SET: sel.balance_filter_set = 1'b1;
			CRB_IMPEDANCE_SCALING_SET: sel.impedance_scaling_set = 1'b1;
			CRB_TRANSMIT_SET: begin
				sel.transmit_gain_set = (index >= CRB_GAIN_HALF_MIN);
				sel.transmit_freq_response_set = (index < CRB_GAIN_HALF_MIN);
			end
			CRB_RECEIVE_SET: begin
				sel.receive_gain_set = (index >= CRB_GAIN_HALF_MIN);
				sel.receive_freq_response_set = (index < CRB_GAIN_HALF_MIN);
			end
			default: valid = 1'b0;
		endcase
	end

endmodule : crb_decode

/* core/crb_access.sv */
`timescale 1ns/100ps
module crb_access
	import crb_pkg::*;
#(
	parameter int DATA_W = CRB_DATA_W
)
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic cmd_valid,
	input crb_cmd_t cmd,
	input wire logic [DATA_W-1:0] wr_data,
	output logic cmd_ready,
	output logic word_strobe,
	output logic [CRB_ADDR_W-1:0] word_addr,
	output logic [DATA_W-1:0] rd_data,
	output crb_sel_t word_sel,
	output logic done
);

	typedef enum logic [1:0] {ST_IDLE, ST_WALK} crb_state_t;

	crb_state_t state_reg;
	logic [CRB_BLK_W-1:0] block_reg;
	logic [CRB_IDX_W-1:0] index_reg;
	logic write_reg;
	logic [DATA_W-1:0] mem_reg [CRB_WORDS];
	crb_sel_t sel_next;
	logic blk_ok;
	logic [CRB_ADDR_W-1:0] addr_next;
	logic [5:0] lin_next;
	logic walk_active;
	logic walk_last;
	logic take_cmd;
	logic wr_any;
	logic [CRB_WORDS-1:0] wr_hit;
	logic [DATA_W-1:0] rd_word;

	// ----------------------------------------
	// Walk control
	// ----------------------------------------
	assign addr_next = {block_reg, index_reg};
	assign lin_next = addr_next;
	assign walk_active = (state_reg == ST_WALK);
	assign walk_last = walk_active && (index_reg == CRB_IDX_LAST);
	assign take_cmd = (state_reg == ST_IDLE) && cmd_valid;
	assign wr_any = walk_active && write_reg && blk_ok;

	// ----------------------------------------
	// Set decode
	// ----------------------------------------
	crb_decode u_decode (
		.block(block_reg),
		.index(index_reg),
		.sel(sel_next),
		.valid(blk_ok)
	);

	// ----------------------------------------
	// Walk state
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (cmd_valid) begin
						state_reg <= ST_WALK;
					end
				end
				ST_WALK: begin
					if (index_reg == CRB_IDX_LAST) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Block capture
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst) begin
			block_reg <= '0;
		end else if (take_cmd) begin
			block_reg <= cmd.block;
		end
	end

	// ----------------------------------------
	// Direction capture
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst) begin
			write_reg <= 1'b0;
		end else if (take_cmd) begin
			write_reg <= cmd.write;
		end
	end

	// ----------------------------------------
	// Word index
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst) begin
			index_reg <= CRB_IDX_FIRST;
		end else if (take_cmd) begin
			index_reg <= CRB_IDX_FIRST;
		end else if (walk_active) begin
			index_reg <= index_reg - 3'h1;
		end
	end

	// ----------------------------------------
	// Coefficient storage
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < CRB_WORDS; gi++) begin : g_word
			assign wr_hit[gi] = wr_any && (lin_next == 6'(gi));
			always_ff @(posedge clock) begin
				if (!nrst) begin
					mem_reg[gi] <= '0;
				end else if (wr_hit[gi]) begin
					mem_reg[gi] <= wr_data;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Read select
	// ----------------------------------------
	always_comb begin
		rd_word = '0;
		if (walk_active && blk_ok) begin
			rd_word = mem_reg[lin_next];
		end
	end

	// ----------------------------------------
	// Word strobe
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst) begin
			word_strobe <= 1'b0;
		end else begin
			word_strobe <= walk_active;
		end
	end

	// ----------------------------------------
	// Word address
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst) begin
			word_addr <= '0;
		end else begin
			word_addr <= addr_next;
		end
	end

	// ----------------------------------------
	// Set select
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst) begin
			word_sel <= '0;
		end else begin
			word_sel <= walk_active ? sel_next : '0;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst) begin
			rd_data <= '0;
		end else begin
			rd_data <= rd_word;
		end
	end

	// ----------------------------------------
	// Walk done
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst) begin
			done <= 1'b0;
		end else begin
			done <= walk_last;
		end
	end

	// ----------------------------------------
	// Command ready
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst) begin
			cmd_ready <= 1'b0;
		end else begin
			cmd_ready <= ((state_reg == ST_IDLE) && !cmd_valid) ||
				walk_last;
		end
	end

endmodule : crb_access

/* verification/crb_properties.sv */
`timescale 1ns/100ps
module crb_properties
	import crb_pkg::*;
#(
	parameter int DATA_W = CRB_DATA_W
)
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic word_strobe,
	input wire logic [CRB_ADDR_W-1:0] word_addr,
	input wire logic [DATA_W-1:0] rd_data,
	input crb_sel_t word_sel,
	input wire logic done
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	logic [2:0] b;
	logic [2:0] w;
	assign b = word_addr[5:3];
	assign w = word_addr[2:0];
	sequence walk8; word_strobe [*8] ##1 !word_strobe; endsequence
	sequence last; word_strobe && w == 3'h0; endsequence
	a_walk_eight: assert property ($rose(word_strobe) |-> walk8)
		else $error("walk length wrong");
	a_first_high: assert property ($rose(word_strobe) |-> w == 3'h7)
		else $error("walk start wrong");
	a_count_down: assert property (word_strobe && w != 3'h0 |=>
		word_strobe && w == $past(w) - 3'h1 && $stable(b))
		else $error("index step wrong");
	a_done_last: assert property (done |-> last)
		else $error("done misplaced");
	a_unmapped_zero: assert property (word_strobe && b > CRB_BLK_MAX |->
		word_sel == '0 && rd_data == '0) else $error("unmapped block");
	a_rx_split: assert property (word_strobe && b == 3'h4 |->
		word_sel == (w[2] ? 7'h02 : 7'h01)) else $error("rx select");
	a_tx_split: assert property (word_strobe && b == 3'h3 |->
		word_sel == (w[2] ? 7'h08 : 7'h04)) else $error("tx select");
	a_set_decode: assert property (word_strobe && b < 3'h3 |->
		word_sel == 7'h40 >> b) else $error("set select");
endmodule : crb_properties
bind crb_access crb_properties #(.DATA_W(DATA_W)) crb_properties_inst (
	.clock(clock), .nrst(nrst), .word_strobe(word_strobe),
	.word_addr(word_addr), .rd_data(rd_data), .word_sel(word_sel),
	.done(done));

/* verification/crb_host_model.sv */
`timescale 1ns/100ps
module crb_host_model
	import crb_pkg::*;
(
	input wire logic clock,
	input wire logic req,
	input crb_cmd_t req_cmd,
	input wire logic [15:0] data,
	output logic cmd_valid = 1'b0,
	output crb_cmd_t cmd = '0,
	output logic [15:0] wr_data = '0
);
	always @(posedge clock) begin
		cmd_valid <= req;
		cmd <= req ? req_cmd : ~req_cmd;
		wr_data <= data;
	end
endmodule : crb_host_model

/* verification/test_coefficient_ram_block_access.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
	$display("[ERR] %0t %h %h", $time, a, e); end end
module test_coefficient_ram_block_access
	import crb_pkg::*;
;
	logic clock = 0, nrst = 0, req = 0, cmd_valid, cmd_ready, word_strobe, done;
	crb_cmd_t cmd, req_cmd = '0;
	logic [15:0] wr_data, rd_data, d = '0;
	logic [5:0] word_addr;
	crb_sel_t word_sel;
	logic [15:0] mem [40];
	logic [31:0] x = 32'hA819;
	logic [2:0] idx;
	int bad_count = 0, n_compared = 0, cyc = 0;
	crb_host_model crb_host_model_inst (.clock, .req, .req_cmd, .data(d),
		.cmd_valid, .cmd, .wr_data);
	crb_access crb_access_inst (.clock, .nrst, .cmd_valid, .cmd, .wr_data,
		.cmd_ready, .word_strobe, .word_addr, .rd_data, .word_sel, .done);
	initial forever #2.5 clock = ~clock;
	function logic [31:0] xs();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	function logic [6:0] sel_exp(input logic [2:0] b, input logic [2:0] i);
		case (b)
			3'h0: return 7'h40;
			3'h1: return 7'h20;
			3'h2: return 7'h10;
			3'h3: return i[2] ? 7'h08 : 7'h04;
			3'h4: return i[2] ? 7'h02 : 7'h01;
			default: return 7'h00;
		endcase
	endfunction : sel_exp
	task finish_test();
		if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test
	task run(input logic w, input logic [2:0] b);
		while (cmd_ready !== 1'b1) @(posedge clock);
		req_cmd <= '{w, b};
		d <= xs();
		idx = 3'h7;
		req <= 1;
		@(posedge clock);
		req <= 0;
		do @(posedge clock); while (done !== 1'b1);
		@(posedge clock);
	endtask : run
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			finish_test();
		end
		if (word_strobe === 1'b1) begin
			`CHK(word_addr, {req_cmd.block, idx})
			if (req_cmd.block < 3'h5) begin
				if (!req_cmd.write) `CHK(rd_data, mem[{req_cmd.block, idx}])
				else mem[{req_cmd.block, idx}] = d;
			end else if (!req_cmd.write) `CHK(rd_data, 16'h0)
			`CHK(word_sel, sel_exp(req_cmd.block, idx))
			`CHK(done, idx == 3'h0)
			`CHK(cmd_ready, idx == 3'h0)
			idx--;
		end
	end
	initial begin
		for (int i = 0; i < 40; i++) mem[i] = '0;
		repeat (3) @(posedge clock);
		nrst <= 1;
		for (int i = 0; i < 16; i++) run(i < 8, i[2:0]);
		for (int i = 0; i < 30; i++) begin
			void'(xs());
			run(x[4], x[9:7]);
		end
		nrst <= 0;
		repeat (2) @(posedge clock);
		nrst <= 1;
		for (int i = 0; i < 40; i++) mem[i] = '0;
		for (int i = 0; i < 5; i++) run(1'b0, i[2:0]);
		finish_test();
	end
endmodule : test_coefficient_ram_block_access
